// [pmseq_params.svh]
// offsets, field positions and reset values of the sequencer
`ifndef PMSEQ_PARAMS_SVH
`define PMSEQ_PARAMS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define PMSEQ_ADDR_ENABLE   3'h0
`define PMSEQ_ADDR_STATUS   3'h1
`define PMSEQ_ADDR_BUCK_V   3'h2
`define PMSEQ_ADDR_LIN1_V   3'h3
`define PMSEQ_ADDR_LIN2_V   3'h4

// ------------------------------------------------------------------
// enable register fields
// ------------------------------------------------------------------
`define PMSEQ_EN_BUCK       0
`define PMSEQ_EN_LIN1       1
`define PMSEQ_EN_LIN2       2
`define PMSEQ_EN_SEQINH     4
`define PMSEQ_EN_RESTART    5

// ------------------------------------------------------------------
// status register fields
// ------------------------------------------------------------------
`define PMSEQ_ST_GOOD_LSB   0
`define PMSEQ_ST_LOWIN      3
`define PMSEQ_ST_OVERTEMP   4
`define PMSEQ_ST_IRQ_EN     7

// ------------------------------------------------------------------
// reset and default values
// ------------------------------------------------------------------
`define PMSEQ_ENABLE_POR    8'h20
`define PMSEQ_DEF_SUPPLIES  3'h7
`define PMSEQ_NOSEQ_SUPPLY  3'h1
`define PMSEQ_BUCK_V_DEF    8'h10
`define PMSEQ_LIN1_V_DEF    8'h14
`define PMSEQ_LIN2_V_DEF    8'h14

`endif

// [pmseq_pkg.sv]
// types shared by the power sequencer
package pmseq_pkg;

    typedef enum logic [1:0] {
        PMSEQ_IDLE,
        PMSEQ_ON,
        PMSEQ_FAULT
    } pmseq_state_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pmseq_bus_req_t;

    typedef struct packed {
        logic [7:0] buck;
        logic [7:0] lin1;
        logic [7:0] lin2;
    } pmseq_volt_t;

endpackage

// [pmseq_ctrl.sv]
// control logic of a three-output power sequencer with fault handling
//
// How it works
// - power-on reset loads every register default
// - enable high at power-on starts default
// - default startup reloads voltages, enables, restart bit
// - enable rising edge, or fault gone with restart bit set, triggers startup
// - enable falling edge turns everything off
// - falling edge ignored after register shutdown
// - enable bits switch supplies, sequenced in order
// - no-sequence variant: inhibit zero, one supply
// - voltage write applies at once when on
// - fault: outputs off, flag set, defaults reloaded
// - fault clears inhibit, keeps restart bit
// - fault gone: restart only if bit set
// - fault flags cleared only by reset or write-one
// - shutdown accepted any time, even in fault
// - power-on reset clears fault flags
// - power-good flags follow hysteresis comparators
// - interrupt low when enabled and flag set
// - write-one clears flag unless fault persists
// - interrupt independent of restart bit, off by default
// - each power-good enables next supply
`include "pmseq_params.svh"
`timescale 1ns/1ps

module pmseq_ctrl #(
    parameter bit SEQ_ENABLED = 1'b1
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    // register port
    input  wire logic [2:0]               reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [7:0]               reg_rdata_o,
    // enable pin and analog monitors (asynchronous)
    input  wire logic                     enable_pin_i,
    input  wire logic                     overtemp_i,
    input  wire logic                     low_input_i,
    input  wire logic [2:0]               power_good_i,
    // supply controls
    output logic                          buck_on_o,
    output logic                          first_linear_on_o,
    output logic                          second_linear_on_o,
    output logic                          bias_on_o,
    output pmseq_pkg::pmseq_volt_t        volt_o,
    output logic                          fault_irq_n_o
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic       en_prev_q;
    logic       first_q;

    always_ff @(posedge clk_i) begin
        sync1_q <= {power_good_i, low_input_i, overtemp_i, enable_pin_i};
        sync2_q <= sync1_q;
    end

    wire       en_s   = sync2_q[0];
    wire       ot_s   = sync2_q[1];
    wire       lv_s   = sync2_q[2];
    wire [2:0] good_s = sync2_q[5:3];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            en_prev_q <= 1'b0;
            first_q   <= 1'b1;
        end else begin
            en_prev_q <= en_s;
            first_q   <= 1'b0;
        end
    end

    // first cycle after reset sees a level as an edge: hot enable
    wire en_rise = en_s & (~en_prev_q | first_q);
    wire en_fall = ~en_s & en_prev_q & ~first_q;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    pmseq_pkg::pmseq_bus_req_t req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    logic [2:0]              supply_q;
    logic                    seqinh_q;
    logic                    restart_q;
    logic                    irq_en_q;
    logic                    ot_flag_q;
    logic                    lv_flag_q;
    logic                    pin_started_q;
    logic                    fault_shut_q;
    pmseq_pkg::pmseq_volt_t  volt_q;
    pmseq_pkg::pmseq_state_t state_q;
    pmseq_pkg::pmseq_state_t state_d;
    logic [7:0]              rdata_q;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] target);
        hit = (a == target);
    endfunction

    wire wr_en  = req.wr & hit(req.addr, `PMSEQ_ADDR_ENABLE);
    wire wr_st  = req.wr & hit(req.addr, `PMSEQ_ADDR_STATUS);
    wire wr_bv  = req.wr & hit(req.addr, `PMSEQ_ADDR_BUCK_V);
    wire wr_l1  = req.wr & hit(req.addr, `PMSEQ_ADDR_LIN1_V);
    wire wr_l2  = req.wr & hit(req.addr, `PMSEQ_ADDR_LIN2_V);

    wire fault_now  = ot_s | lv_s;
    wire fault_set  = fault_now & (state_q != pmseq_pkg::PMSEQ_FAULT);
    wire fault_gone = ~fault_now & (state_q == pmseq_pkg::PMSEQ_FAULT);
    wire do_start   = (en_rise & ~fault_now)
                    | (fault_gone & restart_q & ~fault_shut_q);
    wire all_off_wr = wr_en & (req.wdata[2:0] == 3'h0);
    wire [2:0] def_supplies = SEQ_ENABLED ? `PMSEQ_DEF_SUPPLIES
                                          : `PMSEQ_NOSEQ_SUPPLY;

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            pmseq_pkg::PMSEQ_IDLE: begin
                if (fault_now) begin
                    state_d = pmseq_pkg::PMSEQ_FAULT;
                end else if (do_start || (wr_en && !all_off_wr)) begin
                    state_d = pmseq_pkg::PMSEQ_ON;
                end
            end
            pmseq_pkg::PMSEQ_ON: begin
                if (fault_now) begin
                    state_d = pmseq_pkg::PMSEQ_FAULT;
                end else if ((en_fall && pin_started_q) || all_off_wr) begin
                    state_d = pmseq_pkg::PMSEQ_IDLE;
                end
            end
            pmseq_pkg::PMSEQ_FAULT: begin
                if (fault_gone && restart_q && !fault_shut_q) begin
                    state_d = pmseq_pkg::PMSEQ_ON;
                end else if (fault_gone) begin
                    state_d = pmseq_pkg::PMSEQ_IDLE;
                end
            end
            default: state_d = pmseq_pkg::PMSEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= pmseq_pkg::PMSEQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            supply_q  <= 3'h0;
            seqinh_q  <= 1'b0;
            restart_q <= 1'b1;
        end else if (fault_set) begin
            supply_q  <= 3'h0;
            seqinh_q  <= 1'b0;
        end else if (do_start) begin
            supply_q  <= def_supplies;
            seqinh_q  <= 1'b0;
            restart_q <= 1'b1;
        end else if (en_fall && pin_started_q) begin
            supply_q  <= 3'h0;
        end else if (wr_en) begin
            supply_q  <= req.wdata[2:0];
            seqinh_q  <= SEQ_ENABLED & req.wdata[`PMSEQ_EN_SEQINH];
            restart_q <= req.wdata[`PMSEQ_EN_RESTART];
        end
    end

    // remembers whether the pin owns the current run
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_started_q <= 1'b0;
        end else if (en_rise && !fault_now) begin
            pin_started_q <= 1'b1;
        end else if (all_off_wr || en_fall) begin
            pin_started_q <= 1'b0;
        end
    end

    // a host shutdown while the fault holds cancels the automatic restart;
    // bias stays up until the fault clears, since the monitors need it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fault_shut_q <= 1'b0;
        end else if (state_q != pmseq_pkg::PMSEQ_FAULT) begin
            fault_shut_q <= 1'b0;
        end else if (en_fall || all_off_wr) begin
            fault_shut_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // voltage registers
    // ------------------------------------------------------------------
    wire reload_v = fault_set | do_start;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || reload_v) begin
            volt_q.buck <= `PMSEQ_BUCK_V_DEF;
            volt_q.lin1 <= `PMSEQ_LIN1_V_DEF;
            volt_q.lin2 <= `PMSEQ_LIN2_V_DEF;
        end else begin
            if (wr_bv) volt_q.buck <= req.wdata;
            if (wr_l1) volt_q.lin1 <= req.wdata;
            if (wr_l2) volt_q.lin2 <= req.wdata;
        end
    end

    assign volt_o = volt_q;

    // ------------------------------------------------------------------
    // status, fault flags and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ot_flag_q <= 1'b0;
            lv_flag_q <= 1'b0;
            irq_en_q  <= 1'b0;
        end else begin
            // set wins over a write-one clear while the fault persists
            ot_flag_q <= ot_s | (ot_flag_q & ~(wr_st & req.wdata[`PMSEQ_ST_OVERTEMP]));
            lv_flag_q <= lv_s | (lv_flag_q & ~(wr_st & req.wdata[`PMSEQ_ST_LOWIN]));
            if (wr_st) irq_en_q <= req.wdata[`PMSEQ_ST_IRQ_EN];
        end
    end

    assign fault_irq_n_o = ~(irq_en_q & (ot_flag_q | lv_flag_q));

    // ------------------------------------------------------------------
    // supply drive and sequencing
    // ------------------------------------------------------------------
    // downstream supply waits on the power-good of the nearest enabled upstream one
    wire seq_on = SEQ_ENABLED & ~seqinh_q;
    wire run    = (state_q == pmseq_pkg::PMSEQ_ON);
    wire [2:0] drive;
    assign drive[0] = run & supply_q[0];
    assign drive[1] = run & supply_q[1] & (~seq_on | ~supply_q[0] | good_s[0]);
    assign drive[2] = run & supply_q[2] & (~seq_on
                      | (supply_q[1] ? good_s[1] : (~supply_q[0] | good_s[0])));

    logic [2:0] drive_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            drive_q <= 3'h0;
        end else begin
            drive_q <= drive & {3{~fault_now}};
        end
    end

    assign buck_on_o          = drive_q[0];
    assign first_linear_on_o  = drive_q[1];
    assign second_linear_on_o = drive_q[2];
    assign bias_on_o          = (state_q != pmseq_pkg::PMSEQ_IDLE);

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    wire [7:0] en_word = {2'h0, restart_q, seqinh_q, 1'b0, supply_q};
    wire [7:0] st_word = {irq_en_q, 2'h0, ot_flag_q, lv_flag_q, good_s};
    logic [7:0] rd_mux;
    always_comb begin
        if (hit(req.addr, `PMSEQ_ADDR_ENABLE))      rd_mux = en_word;
        else if (hit(req.addr, `PMSEQ_ADDR_STATUS)) rd_mux = st_word;
        else if (hit(req.addr, `PMSEQ_ADDR_BUCK_V)) rd_mux = volt_q.buck;
        else if (hit(req.addr, `PMSEQ_ADDR_LIN1_V)) rd_mux = volt_q.lin1;
        else if (hit(req.addr, `PMSEQ_ADDR_LIN2_V)) rd_mux = volt_q.lin2;
        else                                        rd_mux = 8'h00;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= req.rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_fault_hit;
        fault_now && state_q != pmseq_pkg::PMSEQ_FAULT;
    endsequence

    sequence s_supplies_dark;
        supply_q == 3'h0 ##1 drive_q == 3'h0;
    endsequence

    sequence s_fault_clears;
        fault_gone && !restart_q;
    endsequence

    sequence s_host_shut;
        state_q == pmseq_pkg::PMSEQ_FAULT && fault_now && (en_fall || all_off_wr);
    endsequence

    a_fault_kills_outputs: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_fault_hit |=> (drive_q == 3'h0) && (supply_q == 3'h0) && !seqinh_q)
        else $error("fault did not switch outputs off");

    a_fault_keeps_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_fault_hit |=> restart_q == $past(restart_q))
        else $error("fault changed restart bit");

    a_rise_starts_default: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (en_rise && !fault_now) |=> supply_q == def_supplies && restart_q
                                    && volt_q.buck == `PMSEQ_BUCK_V_DEF)
        else $error("default startup not loaded");

    a_fall_clears_all: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (en_fall && pin_started_q && !fault_now && !do_start) |=> s_supplies_dark)
        else $error("enable fall left a supply on");

    a_irq_follows_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (irq_en_q && !wr_st && (ot_s || lv_s)) |=> !fault_irq_n_o)
        else $error("interrupt not asserted");

    a_flag_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ot_flag_q && !(wr_st && req.wdata[`PMSEQ_ST_OVERTEMP])) |=> ot_flag_q)
        else $error("overtemp flag lost without clear");

    a_clear_persist: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (lv_s && wr_st && req.wdata[`PMSEQ_ST_LOWIN]) |=> lv_flag_q)
        else $error("persisting fault flag was cleared");

    a_seq_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (seq_on && supply_q[0] && !good_s[0] && !fault_now) |=> !drive_q[1])
        else $error("second supply ran ahead of first");

    a_inhibit_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !SEQ_ENABLED |-> !seqinh_q)
        else $error("inhibit set in no-sequence variant");

    a_no_restart_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_fault_clears |=> !bias_on_o && drive_q == 3'h0)
        else $error("supplies came back with restart bit low");

    a_fault_bias_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_fault_hit |=> bias_on_o)
        else $error("bias dropped on fault");

    a_volt_write_now: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_bv && !reload_v) |=> volt_q.buck == $past(req.wdata))
        else $error("voltage write not applied");

    a_fall_ignored: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (en_fall && !pin_started_q && run && !fault_now && !wr_en)
            |=> run && supply_q == $past(supply_q))
        else $error("enable fall acted after register shutdown");

    a_shut_in_fault: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_host_shut |=> fault_shut_q)
        else $error("shutdown during fault not taken");

    a_shut_stays_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (fault_gone && fault_shut_q) |=> !bias_on_o && drive_q == 3'h0)
        else $error("restart after shutdown in fault");

endmodule // pmseq_ctrl

// [pmseq_supply_model.sv]
// behavioural model of the three regulators and their power-good comparators
`timescale 1ns/1ps

module pmseq_supply_model (
    // clock
    input  wire logic       clk_i,
    // supply drive and soft-start length in cycles
    input  wire logic [2:0] on_i,
    input  wire logic [3:0] ramp_i,
    // comparator outputs
    output logic      [2:0] power_good_o
);
    logic [3:0] ramp_q [3];

    // ------------------------------------------------------------------
    // good only after a full ramp; lost at once when drive drops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (!on_i[i]) begin
                ramp_q[i] <= 4'h0;
            end else if (ramp_q[i] != ramp_i) begin
                ramp_q[i] <= ramp_q[i] + 4'h1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            power_good_o[i] = on_i[i] && (ramp_q[i] == ramp_i);
        end
    end
endmodule // pmseq_supply_model

// [pmseq_ctrl_tb.sv]
// self-checking bench for the power sequencer control block
`timescale 1ns/1ps

module pmseq_ctrl_tb;
    // ------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------
    logic                   clk_i = 1'b0;
    logic                   sys_rst_i = 1'b1;
    logic [2:0]             addr = 3'h0;
    logic [7:0]             wdata = 8'h00;
    logic                   wr = 1'b0;
    logic                   rd = 1'b0;
    logic                   pin = 1'b0;
    logic                   ot = 1'b0;
    logic                   lowin = 1'b0;
    logic [3:0]             dly = 4'h1;
    logic [7:0]             rdata;
    logic [7:0]             rdata_ns;
    logic [2:0]             good;
    logic                   buck, lin1, lin2, bias, irq_n;
    logic [3:0]             obs;
    logic [3:0]             ns_obs;
    pmseq_pkg::pmseq_volt_t volt;
    int                     num_errors = 0;
    int                     tests_run = 0;

    assign obs = {bias, lin2, lin1, buck};
    always #12.5 clk_i = ~clk_i;

    pmseq_ctrl #(.SEQ_ENABLED(1'b1)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .enable_pin_i(pin),
        .overtemp_i(ot), .low_input_i(lowin), .power_good_i(good), .buck_on_o(buck),
        .first_linear_on_o(lin1), .second_linear_on_o(lin2), .bias_on_o(bias),
        .volt_o(volt), .fault_irq_n_o(irq_n));
    // the one-supply variant shares every input
    pmseq_ctrl #(.SEQ_ENABLED(1'b0)) DUT_NOSEQ (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_ns), .enable_pin_i(pin),
        .overtemp_i(ot), .low_input_i(lowin), .power_good_i(good), .buck_on_o(ns_obs[0]),
        .first_linear_on_o(ns_obs[1]), .second_linear_on_o(ns_obs[2]),
        .bias_on_o(ns_obs[3]), .volt_o(), .fault_irq_n_o());
    pmseq_supply_model PARTNER (
        .clk_i(clk_i), .on_i({lin2, lin1, buck}), .ramp_i(dly), .power_good_o(good));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error: %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // fault flag position in the status word for each fault pass
    function automatic logic [7:0] flag_bit(input int f);
        return f ? 8'h08 : 8'h10;
    endfunction

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // bounded wait on the supply and bias outputs
    task automatic wait_obs(input logic [3:0] mask, input logic [3:0] val);
        int n;
        n = 0;
        while ((obs & mask) !== val && n < 100) begin
            idle(1);
            n++;
        end
        chk("outputs", {4'h0, obs & mask}, {4'h0, val});
        if (n >= 100) summarize();
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] v;
        void'($urandom(32'h00f8cc56));
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        idle(10);
        rd_reg(3'h0, d);
        chk("enable reg", d, 8'h20);
        chk("outputs idle", {4'h0, obs}, 8'h00);
        chk("irq idle", {7'h0, irq_n}, 8'h01);
        chk("buck volt", volt.buck, 8'h10);
        chk("lin2 volt", volt.lin2, 8'h14);
        for (int a = 5; a < 8; a++) begin
            rd_reg(3'(a), d);
            chk("unmapped", d, 8'h00);
        end
        $display("test reset done");

        // slow ramp so a chain that skips power-good shows up
        dly <= 4'h6;
        @(posedge clk_i);
        pin <= 1'b1; // no bus traffic while the pin moves
        wait_obs(4'h1, 4'h1);
        chk("lin1 waits good", {7'h0, obs[1]}, 8'h00);
        wait_obs(4'hF, 4'hF);
        rd_reg(3'h0, d);
        chk("enable started", d, 8'h27);
        chk("noseq enable", rdata_ns, 8'h21);
        chk("noseq outputs", {4'h0, ns_obs}, 8'h09);
        idle(12);
        rd_reg(3'h1, d);
        chk("good flags", d, 8'h07);
        for (int i = 0; i < 3; i++) begin
            v = 8'($urandom);
            wr_reg(3'(i + 2), v);
            chk("volt applied", volt[23 - 8 * i -: 8], v);
        end
        @(posedge clk_i);
        pin <= 1'b0;
        wait_obs(4'hF, 4'h0);
        rd_reg(3'h0, d);
        chk("enables cleared", d & 8'h07, 8'h00);
        $display("test pin start and stop done");

        dly <= 4'(1 + $urandom % 8);
        @(posedge clk_i);
        pin <= 1'b1;
        wait_obs(4'hF, 4'hF);
        wr_reg(3'h0, 8'h20);
        wait_obs(4'hF, 4'h0);
        wr_reg(3'h0, 8'h21);
        wait_obs(4'hF, 4'h9);
        wr_reg(3'h0, 8'h33); // inhibit raised with a supply live
        wait_obs(4'hF, 4'hB);
        @(posedge clk_i);
        pin <= 1'b0;
        idle(10);
        chk("fall ignored", {4'h0, obs}, 8'h0B);
        $display("test register control done");

        wr_reg(3'h1, 8'h80);
        for (int f = 0; f < 2; f++) begin
            wr_reg(3'h2, 8'h3C); // off-default so the reload shows
            @(posedge clk_i);
            if (f == 0) ot <= 1'b1;
            else lowin <= 1'b1;
            wait_obs(4'h7, 4'h0);
            chk("bias kept", {7'h0, bias}, 8'h01);
            chk("irq low", {7'h0, irq_n}, 8'h00);
            rd_reg(3'h0, d);
            chk("enable in fault", d, 8'h20);
            chk("volt reload", volt.buck, 8'h10);
            wr_reg(3'h1, 8'h98);
            rd_reg(3'h1, d);
            chk("flag persists", d & 8'h98, 8'h80 | flag_bit(f));
            @(posedge clk_i);
            ot <= 1'b0;
            lowin <= 1'b0;
            wait_obs(4'h7, 4'h7);
            rd_reg(3'h1, d);
            chk("flag kept", d & 8'h18, flag_bit(f));
            wr_reg(3'h1, 8'h98);
            rd_reg(3'h1, d);
            chk("flag cleared", d & 8'h18, 8'h00);
            chk("irq cleared", {7'h0, irq_n}, 8'h01);
        end
        wr_reg(3'h0, 8'h07);
        @(posedge clk_i);
        lowin <= 1'b1;
        wait_obs(4'h7, 4'h0);
        rd_reg(3'h0, d);
        chk("restart bit kept", d, 8'h00);
        @(posedge clk_i);
        lowin <= 1'b0;
        idle(20);
        chk("stays off", {4'h0, obs}, 8'h00);
        chk("irq held", {7'h0, irq_n}, 8'h00);
        $display("test faults done");

        // pin falls while a fault holds: no restart when it clears
        @(posedge clk_i);
        pin <= 1'b1;
        wait_obs(4'hF, 4'hF);
        @(posedge clk_i);
        ot <= 1'b1;
        wait_obs(4'h7, 4'h0);
        @(posedge clk_i);
        pin <= 1'b0;
        idle(6);
        @(posedge clk_i);
        ot <= 1'b0;
        idle(20);
        chk("shut in fault", {4'h0, obs}, 8'h00);
        $display("test shutdown in fault done");

        // supply collapse with the pin tied high
        @(posedge clk_i);
        pin <= 1'b1;
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_reg(3'h1, d);
        chk("flags after reset", d & 8'h98, 8'h00);
        wait_obs(4'h1, 4'h1);
        $display("test hot enable done");
        summarize();
    end
endmodule // pmseq_ctrl_tb
